// *** rtl/pmst_trap_idle_status.sv ***
// Device traps, secondary disk idle, VGA and general timers, and second level SMI status mirrors
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Parallel/serial trap fires SMI on LPT1, LPT2, COM3, COM4 accesses.
// - COM2 excluded when routing select is 11, COM1 when it is 10.
// - Floppy trap fires SMI on the eight primary and secondary floppy ports.
// - Primary disk trap fires SMI within the range chosen by select bit 5.
// - Secondary disk idle timer loads, reloads on access, fires on expiry.
// - Secondary disk trap fires SMI on access, flagged in mirror three bit 5.
// - ACPI timer SMI fires on each toggle of the timer MSB.
// - Game port read SMI on reads to 200h and 201h; writes enabled elsewhere.
// - VGA timer runs when enabled, SMI at zero, independent of power management.
// - VGA timer loads its count only on the enable rising transition.
// - VGA timer SMI shows only in top-level bit 6.
// - Video retrace SMI from serial status bit 7, only in top-level bit 5.
// - General timer two runs when enabled, SMI on expiry, reload on pin 7.
// - General timer one runs when enabled, SMI on expiry, reload on selected events.
// - Traps, idle, game, GPIO, ACPI go to top bit 0; general timers bit 9.
// - Mirror read keeps status; counterpart read at upper index clears it.
// - Mirror one bit 4 flags game port SMI; bits 7 to 5 read zero.
// - Mirror one bits 3:0 flag pins 7,5,4,3 when GPIO, input and SMI-enabled.
// - Mirror two flags the eight device idle timer expiries.
// - Mirror three flags video, secondary idle, parallel/serial, floppy, primary disk.
// - Device traps need the global trap enable.
// - Idle timers count only with global idle enable; clearing freezes them.
module pmst_trap_idle_status (
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                ce,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [7:0]               reg_rdata,
    input  wire pmst_pkg::pmst_io_t  io,
    input  wire logic [7:0]          processor_serial_status,
    input  wire logic                acpi_timer_msb,
    input  wire logic [7:0]          gpio_in,
    input  wire logic [7:0]          gpio_is_gpio,
    input  wire logic [7:0]          gpio_is_input,
    input  wire logic                game_write_smi_en,
    input  wire logic [7:0]          other_idle_expire,
    input  wire logic [6:0]          gt1_events,
    input  wire logic                idle_tick,
    input  wire logic                vga_tick,
    input  wire logic                gt1_tick,
    input  wire logic                gt2_tick,
    output pmst_pkg::pmst_smi_t      smi
);
    logic [7:0]          cfg_r [pmst_pkg::NUM_CFG];
    logic [7:0]          rdata_r;
    logic [7:0]          rdata_nxt;
    logic [4:0]          m1_r;
    logic [7:0]          m2_r;
    logic [7:0]          m3_r;
    logic [4:0]          m1_set;
    logic [7:0]          m2_set;
    logic [7:0]          m3_set;
    pmst_pkg::pmst_smi_t smi_r;
    pmst_pkg::pmst_smi_t smi_nxt;
    logic [7:0]          gpio_d_r;
    logic [7:0]          pss_d_r;
    logic                acpi_d_r;

    wire [7:0] en1  = cfg_r[pmst_pkg::CFG_EN1];
    wire [7:0] en3  = cfg_r[pmst_pkg::CFG_EN3];
    wire [7:0] en4  = cfg_r[pmst_pkg::CFG_EN4];
    wire [7:0] rsel = cfg_r[pmst_pkg::CFG_RSEL];
    wire [7:0] gsmi = cfg_r[pmst_pkg::CFG_GSMI];

    function automatic logic blk8(input logic [15:0] a, input logic [15:0] base);
        blk8 = (a[15:3] == base[15:3]);
    endfunction

    function automatic logic span(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        span = (a >= lo) && (a <= hi);
    endfunction

    // Address decode of the host I/O access
    wire [15:0] a          = io.addr;
    wire        lpt_hit    = blk8(a, pmst_pkg::PORT_LPT1) | span(a, pmst_pkg::PORT_LPT1_X, pmst_pkg::PORT_LPT1_XE)
                           | blk8(a, pmst_pkg::PORT_LPT2) | span(a, pmst_pkg::PORT_LPT2_X, pmst_pkg::PORT_LPT2_XE);
    wire        com1_hit   = blk8(a, pmst_pkg::PORT_COM1) & (rsel[1:0] != pmst_pkg::COM_SEL_COM1);
    wire        com2_hit   = blk8(a, pmst_pkg::PORT_COM2) & (rsel[1:0] != pmst_pkg::COM_SEL_COM2);
    wire        com34_hit  = blk8(a, pmst_pkg::PORT_COM3) | blk8(a, pmst_pkg::PORT_COM4);
    wire        parser_hit = lpt_hit | com1_hit | com2_hit | com34_hit;
    logic       floppy_hit;
    always_comb begin
        floppy_hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            floppy_hit = floppy_hit | (a == pmst_pkg::PORT_FLOPPY[i]);
        end
    end
    // Select bit low: task file block only; high: also the alternate status pair
    wire        pdisk_hit  = blk8(a, pmst_pkg::PORT_DISK_P)
                           | (rsel[pmst_pkg::RS_PDISK] & (a[15:1] == pmst_pkg::PORT_DISK_P_ALT[15:1]));
    wire        sdisk_hit  = blk8(a, pmst_pkg::PORT_DISK_S)
                           | (rsel[pmst_pkg::RS_SDISK] & (a[15:1] == pmst_pkg::PORT_DISK_S_ALT[15:1]));
    wire        game_hit   = (a[15:1] == pmst_pkg::PORT_GAME[15:1]);

    // Edge detection on pin-level inputs
    wire [7:0]  gpio_edge    = gpio_in ^ gpio_d_r;
    wire        video_rise   = processor_serial_status[pmst_pkg::PSS_VIDEO] & ~pss_d_r[pmst_pkg::PSS_VIDEO];
    wire        retrace_rise = processor_serial_status[pmst_pkg::PSS_RETRACE] & ~pss_d_r[pmst_pkg::PSS_RETRACE];
    wire        gpio7_rise   = gpio_in[pmst_pkg::GPIO_GT2_PIN] & ~gpio_d_r[pmst_pkg::GPIO_GT2_PIN];

    // SMI events
    wire        traps_on     = en1[pmst_pkg::EN1_TRAPS];
    wire        acc          = io.valid;
    wire        ev_parser    = traps_on & en3[pmst_pkg::EN3_PARSER] & acc & parser_hit;
    wire        ev_floppy    = traps_on & en3[pmst_pkg::EN3_FLOPPY] & acc & floppy_hit;
    wire        ev_pdisk     = traps_on & en3[pmst_pkg::EN3_PDISK] & acc & pdisk_hit;
    wire        ev_video     = traps_on & en3[pmst_pkg::EN3_VIDEO] & video_rise;
    wire        ev_sdisk     = traps_on & en4[pmst_pkg::EN4_SDISK_TRAP] & acc & sdisk_hit;
    wire        ev_acpi      = en4[pmst_pkg::EN4_ACPI] & (acpi_timer_msb ^ acpi_d_r);
    wire        ev_game      = acc & game_hit
                             & ((~io.write & en4[pmst_pkg::EN4_GAME]) | (io.write & game_write_smi_en));
    wire        ev_retrace   = en4[pmst_pkg::EN4_RETRACE] & retrace_rise;
    wire [3:0]  gpio_sel_edge = {gpio_edge[7], gpio_edge[5], gpio_edge[4], gpio_edge[3]};
    wire [3:0]  gpio_ok      = {gpio_is_gpio[7] & gpio_is_input[7], gpio_is_gpio[5] & gpio_is_input[5],
                                gpio_is_gpio[4] & gpio_is_input[4], gpio_is_gpio[3] & gpio_is_input[3]};
    wire [3:0]  ev_gpio      = gpio_sel_edge & gpio_ok & gsmi[3:0];

    // Timers: one slot each for secondary disk idle, VGA, general two, general one
    logic [pmst_pkg::NUM_TIMERS-1:0] tm_en;
    logic [pmst_pkg::NUM_TIMERS-1:0] tm_reload;
    logic [pmst_pkg::NUM_TIMERS-1:0] tm_run;
    logic [pmst_pkg::NUM_TIMERS-1:0] tm_tick;
    logic [pmst_pkg::NUM_TIMERS-1:0] tm_armed_r;
    logic [pmst_pkg::NUM_TIMERS-1:0] tm_en_d_r;
    logic [pmst_pkg::NUM_TIMERS-1:0] tm_fire_r;
    logic [7:0]                      tm_load [pmst_pkg::NUM_TIMERS];
    logic [7:0]                      tm_cnt_r [pmst_pkg::NUM_TIMERS];

    assign tm_en     = {en4[pmst_pkg::EN4_GT1], en4[pmst_pkg::EN4_GT2], en4[pmst_pkg::EN4_VGA],
                        en4[pmst_pkg::EN4_SDISK_IDLE]};
    // Idle timer freezes with the global idle enable; the others ignore it
    assign tm_run    = {1'b1, 1'b1, 1'b1, en1[pmst_pkg::EN1_IDLE]};
    assign tm_tick   = {gt1_tick, gt2_tick, vga_tick, idle_tick};
    assign tm_reload = {|(gt1_events & cfg_r[pmst_pkg::CFG_GT1E][6:0]),
                        cfg_r[pmst_pkg::CFG_GTC][pmst_pkg::GTC_GPIO7_RELOAD] & gpio7_rise,
                        1'b0,
                        en1[pmst_pkg::EN1_IDLE] & acc & sdisk_hit};
    assign tm_load[pmst_pkg::T_SDISK] = cfg_r[pmst_pkg::CFG_SDC];
    assign tm_load[pmst_pkg::T_VGA]   = cfg_r[pmst_pkg::CFG_VGAC];
    assign tm_load[pmst_pkg::T_GT2]   = cfg_r[pmst_pkg::CFG_GT2C];
    assign tm_load[pmst_pkg::T_GT1]   = cfg_r[pmst_pkg::CFG_GT1C];

    for (genvar t = 0; t < pmst_pkg::NUM_TIMERS; t++) begin : g_timer
        wire start  = tm_en[t] & ~tm_en_d_r[t];
        wire expire = tm_armed_r[t] & tm_run[t] & (tm_cnt_r[t] == 8'h00);
        always_ff @(posedge mclk) begin
            if (reset) begin
                tm_cnt_r[t]   <= 8'h00;
                tm_armed_r[t] <= 1'b0;
                tm_en_d_r[t]  <= 1'b0;
                tm_fire_r[t]  <= 1'b0;
            end else if (ce) begin
                tm_en_d_r[t] <= tm_en[t];
                tm_fire_r[t] <= tm_en[t] & ~start & expire;
                if (!tm_en[t]) begin
                    tm_armed_r[t] <= 1'b0;
                end else if (start || (tm_reload[t] && tm_armed_r[t])) begin
                    tm_cnt_r[t]   <= tm_load[t];
                    tm_armed_r[t] <= 1'b1;
                end else if (expire) begin
                    tm_armed_r[t] <= 1'b0;
                end else if (tm_armed_r[t] && tm_run[t] && tm_tick[t]) begin
                    tm_cnt_r[t] <= tm_cnt_r[t] - 8'h01;
                end
            end
        end
    end

    // Configuration registers
    for (genvar i = 0; i < pmst_pkg::NUM_CFG; i++) begin : g_cfg
        wire we = reg_wr & (reg_addr == pmst_pkg::CFG_IDX[i]);
        always_ff @(posedge mclk) begin
            if (reset) begin
                cfg_r[i] <= pmst_pkg::RESET_BYTE;
            end else if (ce && we) begin
                cfg_r[i] <= reg_wdata;
            end
        end
    end

    // Status mirrors: set wins over the clear-on-read of the counterpart
    wire clr1 = reg_rd & (reg_addr == pmst_pkg::IDX_CLEAR_ONE);
    wire clr2 = reg_rd & (reg_addr == pmst_pkg::IDX_CLEAR_TWO);
    wire clr3 = reg_rd & (reg_addr == pmst_pkg::IDX_CLEAR_THREE);
    assign m1_set = {ev_game, ev_gpio};
    assign m2_set = other_idle_expire;
    assign m3_set = {ev_video, 1'b0, ev_sdisk, tm_fire_r[pmst_pkg::T_SDISK], 1'b0,
                     ev_parser, ev_floppy, ev_pdisk};

    always_ff @(posedge mclk) begin
        if (reset) begin
            m1_r <= 5'h00;
            m2_r <= pmst_pkg::RESET_BYTE;
            m3_r <= pmst_pkg::RESET_BYTE;
        end else if (ce) begin
            m1_r <= m1_set | (m1_r & ~{5{clr1}});
            m2_r <= m2_set | (m2_r & ~{8{clr2}});
            m3_r <= m3_set | (m3_r & ~{8{clr3}});
        end
    end

    // Top-level SMI pulses
    assign smi_nxt.top_bit0 = (|m1_set) | (|m2_set) | (|m3_set) | ev_acpi;
    assign smi_nxt.top_bit9 = tm_fire_r[pmst_pkg::T_GT1] | tm_fire_r[pmst_pkg::T_GT2];
    assign smi_nxt.top_bit6 = tm_fire_r[pmst_pkg::T_VGA];
    assign smi_nxt.top_bit5 = ev_retrace;

    // Read mux; unmapped indices read zero
    always_comb begin
        rdata_nxt = 8'h00;
        for (int i = 0; i < pmst_pkg::NUM_CFG; i++) begin
            if (reg_addr == pmst_pkg::CFG_IDX[i]) begin
                rdata_nxt = cfg_r[i];
            end
        end
        if (reg_addr == pmst_pkg::IDX_MIRROR_ONE || reg_addr == pmst_pkg::IDX_CLEAR_ONE) begin
            rdata_nxt = {3'b000, m1_r};
        end
        if (reg_addr == pmst_pkg::IDX_MIRROR_TWO || reg_addr == pmst_pkg::IDX_CLEAR_TWO) begin
            rdata_nxt = m2_r;
        end
        if (reg_addr == pmst_pkg::IDX_MIRROR_THREE || reg_addr == pmst_pkg::IDX_CLEAR_THREE) begin
            rdata_nxt = m3_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_r  <= 8'h00;
            smi_r    <= '0;
            gpio_d_r <= 8'h00;
            pss_d_r  <= 8'h00;
            acpi_d_r <= 1'b0;
        end else if (ce) begin
            rdata_r  <= reg_rd ? rdata_nxt : 8'h00;
            smi_r    <= smi_nxt;
            gpio_d_r <= gpio_in;
            pss_d_r  <= processor_serial_status;
            acpi_d_r <= acpi_timer_msb;
        end
    end

    assign reg_rdata = rdata_r;
    assign smi       = smi_r;

    property p_parser_trap;
        @(posedge mclk) disable iff (reset)
        ce && traps_on && en3[pmst_pkg::EN3_PARSER] && acc && blk8(a, pmst_pkg::PORT_COM4)
        |=> smi.top_bit0 && m3_r[pmst_pkg::M3_PARSER];
    endproperty
    a_parser_trap: assert property (p_parser_trap) else $error("parser trap missed");

    property p_com2_excluded;
        @(posedge mclk) disable iff (reset)
        ce && acc && blk8(a, pmst_pkg::PORT_COM2) && rsel[1:0] == pmst_pkg::COM_SEL_COM2
        && !m3_r[pmst_pkg::M3_PARSER] |=> !m3_r[pmst_pkg::M3_PARSER];
    endproperty
    a_com2_excluded: assert property (p_com2_excluded) else $error("excluded COM2 trapped");

    property p_floppy_trap;
        @(posedge mclk) disable iff (reset)
        ce && traps_on && en3[pmst_pkg::EN3_FLOPPY] && acc && a == 16'h0375 |=> m3_r[pmst_pkg::M3_FLOPPY];
    endproperty
    a_floppy_trap: assert property (p_floppy_trap) else $error("floppy trap missed");

    property p_vga_load;
        @(posedge mclk) disable iff (reset)
        ce && en4[pmst_pkg::EN4_VGA] && !tm_en_d_r[pmst_pkg::T_VGA]
        |=> tm_cnt_r[pmst_pkg::T_VGA] == $past(cfg_r[pmst_pkg::CFG_VGAC]) && tm_armed_r[pmst_pkg::T_VGA];
    endproperty
    a_vga_load: assert property (p_vga_load) else $error("VGA timer not loaded");

    property p_vga_smi;
        @(posedge mclk) disable iff (reset)
        ce && tm_fire_r[pmst_pkg::T_VGA] |=> smi.top_bit6;
    endproperty
    a_vga_smi: assert property (p_vga_smi) else $error("VGA SMI not reported");

    property p_retrace;
        @(posedge mclk) disable iff (reset)
        ce && en4[pmst_pkg::EN4_RETRACE] && retrace_rise |=> smi.top_bit5 ##1 !smi.top_bit5 || $past(ev_retrace);
    endproperty
    a_retrace: assert property (p_retrace) else $error("retrace SMI wrong");

    property p_clear_read;
        @(posedge mclk) disable iff (reset)
        ce && clr3 && m3_set == 8'h00 |=> m3_r == 8'h00 && reg_rdata == $past(m3_r);
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("counterpart read did not clear");

    property p_mirror_keep;
        @(posedge mclk) disable iff (reset)
        ce && reg_rd && reg_addr == pmst_pkg::IDX_MIRROR_THREE |=> (m3_r & $past(m3_r)) == $past(m3_r);
    endproperty
    a_mirror_keep: assert property (p_mirror_keep) else $error("mirror read cleared status");

    property p_trap_gate;
        @(posedge mclk) disable iff (reset)
        ce && !traps_on |=> (m3_r & ~$past(m3_r) & 8'hEF) == 8'h00;
    endproperty
    a_trap_gate: assert property (p_trap_gate) else $error("trap without global enable");

    property p_idle_freeze;
        @(posedge mclk) disable iff (reset)
        ce && !en1[pmst_pkg::EN1_IDLE] && tm_en_d_r[pmst_pkg::T_SDISK] && tm_en[pmst_pkg::T_SDISK]
        |=> tm_cnt_r[pmst_pkg::T_SDISK] == $past(tm_cnt_r[pmst_pkg::T_SDISK]) && !tm_fire_r[pmst_pkg::T_SDISK];
    endproperty
    a_idle_freeze: assert property (p_idle_freeze) else $error("idle timer moved while frozen");
endmodule

// *** shared/pmst_pkg.sv ***
// Constants and carrier types for the trap, idle timer and SMI status register bank
package pmst_pkg;
    // Register indices on the configuration port
    localparam logic [7:0] IDX_ENABLE_ONE     = 8'h80;
    localparam logic [7:0] IDX_ENABLE_THREE   = 8'h82;
    localparam logic [7:0] IDX_ENABLE_FOUR    = 8'h83;
    localparam logic [7:0] IDX_MIRROR_ONE     = 8'h84;
    localparam logic [7:0] IDX_MIRROR_TWO     = 8'h85;
    localparam logic [7:0] IDX_MIRROR_THREE   = 8'h86;
    localparam logic [7:0] IDX_GT1_COUNT      = 8'h88;
    localparam logic [7:0] IDX_GT1_EVENTS     = 8'h89;
    localparam logic [7:0] IDX_GT2_COUNT      = 8'h8A;
    localparam logic [7:0] IDX_GT_CONTROL     = 8'h8B;
    localparam logic [7:0] IDX_VGA_COUNT      = 8'h8E;
    localparam logic [7:0] IDX_RANGE_SELECT   = 8'h93;
    localparam logic [7:0] IDX_GPIO_SMI_EN    = 8'h97;
    localparam logic [7:0] IDX_SEC_DISK_COUNT = 8'hAC;
    localparam logic [7:0] IDX_CLEAR_ONE      = 8'hF4;
    localparam logic [7:0] IDX_CLEAR_TWO      = 8'hF5;
    localparam logic [7:0] IDX_CLEAR_THREE    = 8'hF6;
    localparam logic [7:0] RESET_BYTE         = 8'h00;

    // Slots of the writable configuration array
    localparam int NUM_CFG = 12;
    localparam int CFG_EN1 = 0, CFG_EN3 = 1, CFG_EN4 = 2, CFG_GT1C = 3, CFG_GT1E = 4, CFG_GT2C = 5;
    localparam int CFG_GTC = 6, CFG_VGAC = 7, CFG_RSEL = 8, CFG_GSMI = 9, CFG_SDC = 10, CFG_SPARE = 11;
    localparam logic [7:0] CFG_IDX [NUM_CFG] = '{IDX_ENABLE_ONE, IDX_ENABLE_THREE, IDX_ENABLE_FOUR,
        IDX_GT1_COUNT, IDX_GT1_EVENTS, IDX_GT2_COUNT, IDX_GT_CONTROL, IDX_VGA_COUNT,
        IDX_RANGE_SELECT, IDX_GPIO_SMI_EN, IDX_SEC_DISK_COUNT, 8'h8C};

    // Field positions
    localparam int EN1_IDLE = 1, EN1_TRAPS = 2;
    localparam int EN3_PDISK = 0, EN3_FLOPPY = 1, EN3_PARSER = 2, EN3_VIDEO = 7;
    localparam int EN4_GT1 = 0, EN4_GT2 = 1, EN4_RETRACE = 2, EN4_VGA = 3;
    localparam int EN4_GAME = 4, EN4_ACPI = 5, EN4_SDISK_TRAP = 6, EN4_SDISK_IDLE = 7;
    localparam int RS_SDISK = 4, RS_PDISK = 5, GTC_GPIO7_RELOAD = 5;
    localparam int PSS_VIDEO = 0, PSS_RETRACE = 7, GPIO_GT2_PIN = 7;
    localparam int M1_GAME = 4;
    localparam int M3_PDISK = 0, M3_FLOPPY = 1, M3_PARSER = 2, M3_SDISK_IDLE = 4, M3_SDISK_TRAP = 5, M3_VIDEO = 7;
    localparam logic [1:0] COM_SEL_COM1 = 2'b10;
    localparam logic [1:0] COM_SEL_COM2 = 2'b11;

    // Timer slots
    localparam int NUM_TIMERS = 4;
    localparam int T_SDISK = 0, T_VGA = 1, T_GT2 = 2, T_GT1 = 3;

    // Port addresses; eight-byte blocks compare addr[15:3]
    localparam logic [15:0] PORT_LPT1 = 16'h0378, PORT_LPT1_X = 16'h0778, PORT_LPT1_XE = 16'h077A;
    localparam logic [15:0] PORT_LPT2 = 16'h0278, PORT_LPT2_X = 16'h0678, PORT_LPT2_XE = 16'h067A;
    localparam logic [15:0] PORT_COM1 = 16'h03F8, PORT_COM2 = 16'h02F8;
    localparam logic [15:0] PORT_COM3 = 16'h03E8, PORT_COM4 = 16'h02E8;
    localparam logic [15:0] PORT_FLOPPY [8] = '{16'h03F2, 16'h03F4, 16'h03F5, 16'h03F7,
                                               16'h0372, 16'h0373, 16'h0375, 16'h0377};
    localparam logic [15:0] PORT_GAME = 16'h0200;
    localparam logic [15:0] PORT_DISK_P = 16'h01F0, PORT_DISK_P_ALT = 16'h03F6;
    localparam logic [15:0] PORT_DISK_S = 16'h0170, PORT_DISK_S_ALT = 16'h0376;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
    } pmst_io_t;

    typedef struct packed {
        logic top_bit9;
        logic top_bit6;
        logic top_bit5;
        logic top_bit0;
    } pmst_smi_t;
endpackage

// *** verification/pmst_host_model.sv ***
// Host model that issues single-cycle I/O accesses toward the trap logic
`timescale 1ns/1ps
module pmst_host_model (
    input  wire logic          mclk,
    output pmst_pkg::pmst_io_t io
);
    initial io = '0;
    // Released lines carry inverted values so a stale address never looks like a live access
    task automatic access(input logic [15:0] addr, input logic wr);
        @(posedge mclk);
        io <= '{valid: 1'b1, write: wr, addr: addr};
        @(posedge mclk);
        io <= '{valid: 1'b0, write: ~wr, addr: ~addr};
    endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the trap, timer and status register bank
`timescale 1ns/1ps
module tb;
    logic                mclk = 0, reset = 1, ce = 1, reg_wr = 0, reg_rd = 0, acpi = 0, game_wr = 0, rd_seen = 0;
    logic [7:0]          reg_addr = '0, reg_wdata = '0, reg_rdata, pss = '0, gpio_in = '0, gcfg = '0, oie = '0;
    logic [3:0]          ticks = '0;
    logic [6:0]          gt1_ev = '0;
    logic [31:0]         seed = 32'h8bf6_8f20;
    pmst_pkg::pmst_io_t  io;
    pmst_pkg::pmst_smi_t smi;
    logic [7:0]          rd_q[$];
    logic [3:0]          smi_q[$];
    int                  mismatches = 0, comparisons = 0;

    pmst_host_model host_u (.mclk(mclk), .io(io));
    pmst_trap_idle_status dut_u (.mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io(io), .processor_serial_status(pss),
        .acpi_timer_msb(acpi), .gpio_in(gpio_in), .gpio_is_gpio(gcfg), .gpio_is_input(gcfg),
        .game_write_smi_en(game_wr), .other_idle_expire(oie), .gt1_events(gt1_ev), .idle_tick(ticks[0]),
        .vga_tick(ticks[1]), .gt1_tick(ticks[2]), .gt2_tick(ticks[3]), .smi(smi));

    always #2.5 mclk = ~mclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        @(posedge mclk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask

    task automatic acc(input logic [15:0] a, input logic w, input logic [3:0] exp);
        if (exp != 4'h0) smi_q.push_back(exp);
        host_u.access(a, w);
        repeat (3) @(posedge mclk);
    endtask

    task automatic close_out();
        check("smi pending", 8'(smi_q.size()), 8'h00);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Timebase ticks are random so the timers see uneven decrement rates
    always @(posedge mclk) begin
        seed <= xs(seed);
        ticks <= seed[3:0];
        gt1_ev <= seed[10:4];
        if (rd_seen) check("reg_rdata", reg_rdata, rd_q.size() != 0 ? rd_q.pop_front() : 8'hxx);
        if (smi !== 4'h0) check("smi", {4'h0, smi}, {4'h0, smi_q.size() != 0 ? smi_q.pop_front() : 4'hx});
        rd_seen <= reg_rd;
    end

    initial begin
        logic [7:0] v;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 3; i < 7; i++) rd(8'h80 + 8'(i), 8'h00);
        v = seed[7:0] & 8'h74;
        wr(8'h83, v);
        rd(8'h83, v);
        wr(8'h80, 8'h04);
        wr(8'h82, 8'h07);
        wr(8'h83, 8'h40);
        acc(16'h037C, 1'b0, 4'h1);
        acc(16'h02EC, 1'b1, 4'h1);
        rd(8'h86, 8'h04);
        rd(8'h86, 8'h04);
        rd(8'hF6, 8'h04);
        rd(8'h86, 8'h00);
        // Clock enable low: an access in that window must leave no trace
        ce <= 1'b0;
        acc(16'h037C, 1'b0, 4'h0);
        ce <= 1'b1;
        foreach (pmst_pkg::PORT_FLOPPY[i]) acc(pmst_pkg::PORT_FLOPPY[i], 1'b1, 4'h1);
        wr(8'h93, 8'h02);
        acc(16'h03FA, 1'b0, 4'h0);
        wr(8'h93, 8'h03);
        acc(16'h02FC, 1'b0, 4'h0);
        acc(16'h03F9, 1'b0, 4'h1);
        acc(16'h01F3, 1'b0, 4'h1);
        acc(16'h0171, 1'b1, 4'h1);
        rd(8'hF6, 8'h27);
        wr(8'h80, 8'h00);
        acc(16'h0278, 1'b0, 4'h0);
        wr(8'h83, 8'h10);
        acc(16'h0201, 1'b0, 4'h1);
        acc(16'h0200, 1'b1, 4'h0);
        game_wr <= 1'b1;
        acc(16'h0200, 1'b1, 4'h1);
        rd(8'hF4, 8'h10);
        wr(8'h83, 8'h24);
        smi_q.push_back(4'h2);
        pss <= 8'h80;
        repeat (3) @(posedge mclk);
        smi_q.push_back(4'h1);
        acpi <= 1'b1;
        gcfg <= 8'hFF;
        wr(8'h97, 8'h01);
        smi_q.push_back(4'h1);
        gpio_in <= 8'h08;
        repeat (3) @(posedge mclk);
        rd(8'h84, 8'h01);
        // Pin 4 is not SMI-enabled, so its edge must stay silent
        gpio_in <= 8'h18;
        repeat (3) @(posedge mclk);
        smi_q.push_back(4'h1);
        oie <= 8'h80;
        @(posedge mclk);
        oie <= 8'h00;
        repeat (3) @(posedge mclk);
        rd(8'hF5, 8'h80);
        wr(8'h83, 8'h00);
        smi_q.push_back(4'h4);
        wr(8'h8E, 8'h05);
        wr(8'h83, 8'h08);
        // A count write while running must not reload; the timer still ends on the old count
        wr(8'h8E, 8'hFF);
        repeat (40) @(posedge mclk);
        wr(8'h83, 8'h00);
        // Random events keep reloading timer one, so it must not expire until they are deselected
        wr(8'h88, 8'h06);
        wr(8'h89, 8'h7F);
        wr(8'h83, 8'h01);
        repeat (40) @(posedge mclk);
        smi_q.push_back(4'h8);
        wr(8'h89, 8'h00);
        repeat (60) @(posedge mclk);
        // Pin 7 rising every 8 cycles reloads timer two before its 16 ticks run out
        wr(8'h8A, 8'h10);
        wr(8'h8B, 8'h20);
        wr(8'h83, 8'h02);
        for (int k = 0; k < 8; k++) begin
            gpio_in <= 8'h98;
            repeat (4) @(posedge mclk);
            gpio_in <= 8'h18;
            repeat (4) @(posedge mclk);
        end
        smi_q.push_back(4'h8);
        repeat (100) @(posedge mclk);
        // Idle timer armed with the global idle enable off stays frozen
        wr(8'hAC, 8'h20);
        wr(8'h83, 8'h80);
        repeat (150) @(posedge mclk);
        wr(8'h80, 8'h02);
        for (int k = 0; k < 20; k++) acc(16'h0172, 1'b0, 4'h0);
        smi_q.push_back(4'h1);
        repeat (150) @(posedge mclk);
        rd(8'h86, 8'h10);
        close_out();
    end
endmodule
